// *** design/ims_pkg.sv ***
package ims_pkg;

    // ==========================================================
    // Descriptor field layout.
    localparam int MASK_LSB = 0;
    localparam int RES0_LSB = 8;
    localparam int RES1_LSB = 11;
    localparam int FRAME_LSB = 3;
    localparam int RES_W = 3;

    // Result bit positions.
    localparam int RES_XACT_ERR = 0;
    localparam int RES_BABBLE = 1;
    localparam int RES_UNDERRUN = 2;

    // Reset values.
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [2:0] RES_RST = 3'h0;
    localparam logic [4:0] FRAME_RST = 5'h00;

    // Register offsets of the plain register port.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_FRAME = 4'h1;
    localparam logic [3:0] OFS_STAT = 4'h2;

    // Completion report from the transaction engine.
    typedef struct packed {
        logic valid;
        logic [2:0] uframe;
        logic is_in;
        logic xact_err;
        logic babble;
        logic underrun;
    } ims_done_t;

    // Issue request towards the transaction engine.
    typedef struct packed {
        logic valid;
        logic [2:0] uframe;
    } ims_issue_t;

endpackage

// *** design/ims_sched.sv ***
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
module ims_sched
    import ims_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [4:0] bus_frame_i,
    input wire logic [2:0] bus_uframe_i,
    input wire logic uframe_start_i,
    input wire ims_done_t done_i,
    output ims_issue_t issue_o
);

    // ==========================================================
    // State.
    logic [7:0] microframe_enable_mask_ff;
    logic [4:0] descriptor_word_two_frame_field_ff;
    logic [2:0] uframe_zero_result_ff;
    logic [2:0] uframe_one_result_ff;
    logic [7:0] pending_ff;
    ims_issue_t issue_ff;
    logic frame_match;
    logic [7:0] nxt_mask;
    logic [2:0] done_res;

    // Decodes a write strobe aimed at one register index.
    function automatic logic reg_write(input logic [3:0] a, input logic w,
                                       input logic [3:0] ofs);
        return w && (a == ofs);
    endfunction

    // Frame match gates all scheduling.
    assign frame_match = (descriptor_word_two_frame_field_ff == bus_frame_i);

    // Build the three-bit result from the engine status.
    assign done_res = {~done_i.is_in & done_i.underrun,
                       done_i.is_in & done_i.babble,
                       done_i.xact_err};

    // Mask update: software set ORs in, completion clears its bit; set wins.
    // The OR means a written zero never clears a bit; only completions do.
    always_comb begin
        nxt_mask = microframe_enable_mask_ff;
        if (done_i.valid && pending_ff[done_i.uframe]) begin
            nxt_mask[done_i.uframe] = 1'b0;
        end
        if (reg_write(addr_i, wr_i, OFS_CTRL)) begin
            nxt_mask = nxt_mask | wdata_i[7:0];
        end
    end

    // ==========================================================
    // Mask register.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            microframe_enable_mask_ff <= MASK_RST;
        end else begin
            microframe_enable_mask_ff <= nxt_mask;
        end
    end

    // Frame field register.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            descriptor_word_two_frame_field_ff <= FRAME_RST;
        end else if (reg_write(addr_i, wr_i, OFS_FRAME)) begin
            descriptor_word_two_frame_field_ff <= wdata_i[FRAME_LSB +: 5];
        end
    end

    // Issue decision at each microframe start.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            issue_ff <= '0;
            pending_ff <= 8'h00;
        end else begin
            issue_ff.valid <= 1'b0;
            // A completion clears its pending bit first, so a new issue for the same
            // microframe in that cycle keeps the bit set.
            if (done_i.valid) begin
                pending_ff[done_i.uframe] <= 1'b0;
            end
            if (uframe_start_i && frame_match
                && microframe_enable_mask_ff[bus_uframe_i]) begin
                issue_ff.valid <= 1'b1;
                issue_ff.uframe <= bus_uframe_i;
                pending_ff[bus_uframe_i] <= 1'b1;
            end
        end
    end

    // Result write-back only for processed scheduled microframes zero and one.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            uframe_zero_result_ff <= RES_RST;
            uframe_one_result_ff <= RES_RST;
        end else if (done_i.valid && pending_ff[done_i.uframe]) begin
            if (done_i.uframe == 3'h0) begin
                uframe_zero_result_ff <= done_res;
            end
            if (done_i.uframe == 3'h1) begin
                uframe_one_result_ff <= done_res;
            end
        end
    end

    // Read data one cycle after the strobe.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                OFS_CTRL: rdata_o <= {18'h0, uframe_one_result_ff, uframe_zero_result_ff,
                                      microframe_enable_mask_ff};
                OFS_FRAME: rdata_o <= {24'h0, descriptor_word_two_frame_field_ff, 3'h0};
                OFS_STAT: rdata_o <= {23'h0, frame_match, pending_ff};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    assign issue_o = issue_ff;

    // ==========================================================
    // Checks.
    // An issue pulse needs a matched frame and a set mask bit one cycle before.
    property p_issue_match;
        @(posedge core_clk_i) disable iff (rst_i)
        issue_o.valid |-> $past(frame_match) && $past(microframe_enable_mask_ff[bus_uframe_i]);
    endproperty
    a_issue_match: assert property (p_issue_match) else $error("issue without match");

    // A started microframe with its bit set is issued under its own index.
    property p_issue_uf;
        @(posedge core_clk_i) disable iff (rst_i)
        (uframe_start_i && frame_match && microframe_enable_mask_ff[bus_uframe_i])
        |=> issue_o.valid && issue_o.uframe == $past(bus_uframe_i);
    endproperty
    a_issue_uf: assert property (p_issue_uf) else $error("issue for wrong microframe");

    // A frame that does not match never issues.
    property p_no_match;
        @(posedge core_clk_i) disable iff (rst_i)
        (uframe_start_i && !frame_match) |=> !issue_o.valid;
    endproperty
    a_no_match: assert property (p_no_match) else $error("issue on unmatched frame");

    // A processed microframe loses its mask bit unless software sets it again.
    property p_clear;
        @(posedge core_clk_i) disable iff (rst_i)
        (done_i.valid && pending_ff[done_i.uframe] && !reg_write(addr_i, wr_i, OFS_CTRL))
        |=> !microframe_enable_mask_ff[$past(done_i.uframe)];
    endproperty
    a_clear: assert property (p_clear) else $error("mask bit not cleared");

    // Microframe zero result follows the reported flags, gated by direction.
    property p_r0;
        @(posedge core_clk_i) disable iff (rst_i)
        (done_i.valid && pending_ff[0] && done_i.uframe == 3'h0)
        |=> uframe_zero_result_ff == {$past(!done_i.is_in && done_i.underrun),
        $past(done_i.is_in && done_i.babble), $past(done_i.xact_err)};
    endproperty
    a_r0: assert property (p_r0) else $error("result zero wrong");

    // Microframe one result follows the reported flags, gated by direction.
    property p_r1;
        @(posedge core_clk_i) disable iff (rst_i)
        (done_i.valid && pending_ff[1] && done_i.uframe == 3'h1)
        |=> uframe_one_result_ff == {$past(!done_i.is_in && done_i.underrun),
        $past(done_i.is_in && done_i.babble), $past(done_i.xact_err)};
    endproperty
    a_r1: assert property (p_r1) else $error("result one wrong");

    // Without a processed completion both result fields keep their content.
    property p_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        !(done_i.valid && pending_ff[done_i.uframe]) |=> $stable(uframe_zero_result_ff)
        && $stable(uframe_one_result_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed unscheduled");

    // An IN completion for microframe zero never records underrun.
    property p_bits;
        @(posedge core_clk_i) disable iff (rst_i)
        (done_i.valid && pending_ff[0] && done_i.uframe == 3'h0 && done_i.is_in)
        |=> !uframe_zero_result_ff[RES_UNDERRUN];
    endproperty
    a_bits: assert property (p_bits) else $error("underrun on IN");

    // An OUT completion for microframe one never records babble.
    property p_babble;
        @(posedge core_clk_i) disable iff (rst_i)
        (done_i.valid && pending_ff[1] && done_i.uframe == 3'h1 && !done_i.is_in)
        |=> !uframe_one_result_ff[RES_BABBLE];
    endproperty
    a_babble: assert property (p_babble) else $error("babble on OUT");

    // Every bit that software writes as one is set in the next cycle.
    property p_set;
        @(posedge core_clk_i) disable iff (rst_i)
        reg_write(addr_i, wr_i, OFS_CTRL) |=> (microframe_enable_mask_ff & $past(wdata_i[7:0]))
        == $past(wdata_i[7:0]);
    endproperty
    a_set: assert property (p_set) else $error("software set lost");

    c_issue: cover property (@(posedge core_clk_i) issue_o.valid);
    c_unmatched: cover property (@(posedge core_clk_i) uframe_start_i && !frame_match);
    c_done0: cover property (@(posedge core_clk_i) done_i.valid && done_i.uframe == 3'h0);
    c_done1: cover property (@(posedge core_clk_i) done_i.valid && done_i.uframe == 3'h1);

endmodule

// *** sim/ims_engine_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// Transaction engine model: answers the latest issue after lat_i idle cycles; a new issue restarts the count.
module ims_engine_model
    import ims_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire ims_issue_t issue_i,
    input wire logic [3:0] lat_i,
    input wire logic [3:0] flags_i,
    output ims_done_t done_o
);
    logic [3:0] cnt_ff;
    logic [2:0] uf_ff;
    logic busy_ff;
    // Latches the request, counts the latency down, then pulses one report.
    // The flags are {is_in, error, babble, underrun}, passed on ungated so that the
    // scheduler's own direction gating is what the bench exercises.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
            uf_ff <= 3'h0;
            done_o <= '0;
        end else begin
            done_o <= '0;
            if (issue_i.valid) begin
                busy_ff <= 1'b1;
                cnt_ff <= lat_i;
                uf_ff <= issue_i.uframe;
            end else if (busy_ff && cnt_ff == 4'h0) begin
                busy_ff <= 1'b0;
                done_o <= {1'b1, uf_ff, flags_i};
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule

// *** sim/test_ims_sched.sv ***
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the microframe scheduler.
module test_ims_sched
    import ims_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [4:0] frame = 5'h0b;
    logic [2:0] uframe = 3'h0;
    logic start = 1'b0;
    logic [3:0] lat = 4'h3;
    logic [3:0] flags = 4'hb;
    ims_done_t done;
    ims_issue_t issue;
    int fail_count = 0;
    int cmp_count = 0;

    ims_sched u_dut (.core_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .bus_frame_i(frame), .bus_uframe_i(uframe),
        .uframe_start_i(start), .done_i(done), .issue_o(issue));
    ims_engine_model u_eng (.core_clk_i(clk), .rst_i(rst), .issue_i(issue), .lat_i(lat),
        .flags_i(flags), .done_o(done));

    // Clock at 25 MHz.
    initial begin
        forever #20 clk = ~clk;
    end

    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares one issue pulse; the microframe counts only when a pulse is expected.
    task automatic chk_issue(input ims_issue_t got, input ims_issue_t exp);
        cmp_count++;
        if (got.valid !== exp.valid || (exp.valid && got.uframe !== exp.uframe)) begin
            fail_count++;
            $display("ERROR at %0t: issue got %h expected %h", $time, got, exp);
        end
    endtask

    // Register port write and read, one strobe cycle each.
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // Starts one microframe, checks the issue pulse, lets the engine answer.
    task automatic ustart(input logic [2:0] uf, input logic exp);
        @(posedge clk);
        start <= 1'b1;
        uframe <= uf;
        @(posedge clk);
        start <= 1'b0;
        #1;
        chk_issue(issue, {exp, uf});
        repeat (8) @(posedge clk);
    endtask

    // A set mask bit in a frame that does not match must not issue.
    task automatic t_mismatch();
        wr_reg(OFS_FRAME, 32'h0000_0050);
        wr_reg(OFS_CTRL, 32'h0000_0001);
        ustart(3'h0, 1'b0);
        rd_reg(OFS_CTRL, 32'h0000_0001);
        rd_reg(OFS_FRAME, 32'h0000_0050);
        rd_reg(OFS_STAT, 32'h0000_0000);
        $display("Test mismatch done");
    endtask

    // Matched frame, mask 0x05, IN replies with babble and underrun flagged.
    task automatic t_sched();
        @(posedge clk);
        frame <= 5'h0a;
        wr_reg(OFS_CTRL, 32'h0000_0004);
        for (int i = 0; i < 8; i++) ustart(3'(i), i == 0 || i == 2);
        rd_reg(OFS_CTRL, 32'h0000_0200);
        rd_reg(OFS_STAT, 32'h0000_0100);
        $display("Test schedule done");
    endtask

    // Microframe one, OUT with error and underrun, prompt reply.
    task automatic t_uf1();
        @(posedge clk);
        lat <= 4'h0;
        flags <= 4'h7;
        wr_reg(OFS_CTRL, 32'h0000_0002);
        wr_reg(OFS_CTRL, 32'h0000_0000);
        rd_reg(OFS_CTRL, 32'h0000_0202);
        ustart(3'h1, 1'b1);
        rd_reg(OFS_CTRL, 32'h0000_2a00);
        rd_reg(4'h3, 32'h0000_0000);
        $display("Test microframe one done");
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_mismatch();
        t_sched();
        t_uf1();
        complete_run();
    end

    // Watchdog well past the expected run length.
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule
